// ---- core/ppa_top.sv ----
// Purpose: master address register, pin enables and slave buffer status of a parallel port
// Assumes: host strobes active high, asynchronous to clk_i, held for at least three clocks
// Notes: one-cycle wishbone answer; registers in bits 15:0
// What this block does
// (R1) bit 15 is second select when field 10/01
// (R2) bit 14 is first select only when field 10
// (R3) bits 13:0 hold the master destination address
// (R4) enhanced slave mode: address register is output buffer
// (R5) top pin enable gives pin 15 to port
// (R6) pin 14 enable gives pin 14 to port
// (R7) enables 13:2 make pins address lines
// (R8) enables 1:0 make pins address or latch
// (R9) input all-full reads one only when all full
// (R10) host write to full input sets overflow
// (R11) input full set by data, cleared by read
// (R12) output all-empty reads one only when all empty
// (R13) host read of empty output sets underflow
// (R14) output empty cleared by software buffer write
// (R15) status bits 13:12 and 5:4 read zero
// (R16) select field: 10 both, 01 second, 00 none
// (R17) step mode: increment, decrement, hold, buffer walk
// (R18) interrupt mode 11 fires on buffer three access
// (R19) overflowing host write keeps the old data
// (R20) summary flags are AND of individual flags
`timescale 1ns/1ps
module ppa_top
  import ppa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ppa_pkg::ppa_host_t host_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_o,
  output logic [15:0] port_addr_o,
  output logic [15:0] port_pin_en_o,
  output logic chip_select_one_o,
  output logic chip_select_two_o,
  output logic [7:0] master_data_o,
  output logic master_wr_o,
  output logic [15:0] pad_cfg_o,
  output logic irq_o
);
  import ppa_pkg::*;

  logic [15:0] ctrl_q;
  logic [15:0] addr_q;
  logic [15:0] aen_q;
  logic [15:0] pad_q;
  logic [7:0] in_buf_q [4];
  logic [7:0] out_buf_q [4];
  logic [3:0] in_full_q;
  logic [3:0] out_empty_q;
  logic input_overflow_q;
  logic output_underflow_q;
  logic [1:0] in_ptr_q;
  logic [1:0] out_ptr_q;
  ppa_host_t sync1_q;
  ppa_host_t sync2_q;
  logic rd_s3_q;
  logic wr_s3_q;
  logic ack_q;
  logic [31:0] rdat_q;

  logic [1:0] select_function_field;
  logic [1:0] mode;
  logic [1:0] step;
  logic [1:0] interrupt_mode_field;
  logic enh;
  logic req;
  logic wr_req;
  logic rd_req;
  logic [15:0] wmask;
  logic [15:0] status;
  logic [15:0] wdat;
  logic host_wr_ev;
  logic host_rd_ev;
  logic [1:0] in_idx;
  logic [1:0] out_idx;
  logic [15:0] amask;
  logic [15:0] a_next;
  logic master_go;

  assign select_function_field = ctrl_q[CSF_LSB +: 2];
  assign mode = ctrl_q[MODE_LSB +: 2];
  assign step = ctrl_q[STEP_LSB +: 2];
  assign interrupt_mode_field = ctrl_q[INTERRUPT_MODE_FIELD_LSB +: 2];
  assign enh = (mode == MODE_ENH);
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_req = req & wb_we_i;
  assign rd_req = req & ~wb_we_i;
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdat = wb_dat_i[15:0];

  // summary flags and fixed zero holes
  assign status = {&in_full_q, input_overflow_q, 2'b00, in_full_q,
                   &out_empty_q, output_underflow_q, 2'b00, out_empty_q}; // R9 R12 R15 R20

  // host pins: two-flop sync, edges seen past the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      rd_s3_q <= 1'b0;
      wr_s3_q <= 1'b0;
    end else begin
      sync1_q <= host_i;
      sync2_q <= sync1_q;
      rd_s3_q <= sync2_q.rd;
      wr_s3_q <= sync2_q.wr;
    end
  end

  assign host_wr_ev = sync2_q.cs & sync2_q.wr & ~wr_s3_q & (mode == MODE_LEGACY | enh);
  assign host_rd_ev = sync2_q.cs & sync2_q.rd & ~rd_s3_q & (mode == MODE_LEGACY | enh);
  // buffer selection by address pins or walking pointer
  assign in_idx = enh ? sync2_q.addr : (step == STEP_BUF ? in_ptr_q : 2'b00); // R17
  assign out_idx = enh ? sync2_q.addr : (step == STEP_BUF ? out_ptr_q : 2'b00); // R17

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_ptr_q <= 2'b00;
      out_ptr_q <= 2'b00;
    end else begin
      if (host_wr_ev && !enh && step == STEP_BUF)
        in_ptr_q <= in_ptr_q + 2'b01; // R17
      if (host_rd_ev && !enh && step == STEP_BUF)
        out_ptr_q <= out_ptr_q + 2'b01; // R17
    end
  end

  // control, pad and pin enable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      aen_q <= AEN_RST;
      pad_q <= PAD_RST;
    end else if (wr_req) begin
      if (wb_adr_i == OFF_CTRL)
        ctrl_q <= (ctrl_q & ~wmask) | (wdat & wmask);
      if (wb_adr_i == OFF_AEN)
        aen_q <= (aen_q & ~wmask) | (wdat & wmask);
      if (wb_adr_i == OFF_PAD)
        pad_q <= (pad_q & ~wmask) | (wdat & wmask & PAD_MASK);
    end
  end

  // address bits that act as address under the select field
  always_comb begin
    if (select_function_field == CSF_BOTH)
      amask = 16'h3FFF; // R1 R2 R16
    else if (select_function_field == CSF_TWO)
      amask = 16'h7FFF; // R1 R2 R16
    else
      amask = 16'hFFFF; // R1 R2 R16
    unique case (step)
      STEP_INC: a_next = (addr_q & ~amask) | ((addr_q + 16'h0001) & amask); // R17
      STEP_DEC: a_next = (addr_q & ~amask) | ((addr_q - 16'h0001) & amask); // R17
      default: a_next = addr_q; // R17
    endcase
  end

  assign master_go = wr_req & (wb_adr_i == OFF_MDATA) & ~enh & (mode != MODE_LEGACY);

  // address register; in enhanced slave mode it is not touched
  always_ff @(posedge clk_i) begin
    if (rst_i)
      addr_q <= ADDR_RST;
    else if (wr_req && wb_adr_i == OFF_ADDR && !enh)
      addr_q <= (addr_q & ~wmask) | (wdat & wmask); // R3
    else if (master_go)
      addr_q <= a_next; // R17
  end

  // master write cycle and pin drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_wr_o <= 1'b0;
      master_data_o <= 8'h00;
      port_addr_o <= 16'h0000;
      port_pin_en_o <= 16'h0000;
      chip_select_one_o <= 1'b0;
      chip_select_two_o <= 1'b0;
      pad_cfg_o <= 16'h0000;
    end else begin
      master_wr_o <= master_go;
      if (master_go)
        master_data_o <= wdat[7:0];
      port_addr_o <= addr_q & amask & aen_q; // R3 R7 R8
      port_pin_en_o <= aen_q; // R5 R6 R7 R8
      chip_select_one_o <= aen_q[14] & (select_function_field == CSF_BOTH) & addr_q[14]; // R2 R6
      chip_select_two_o <= aen_q[15] & (select_function_field == CSF_BOTH || select_function_field == CSF_TWO) & addr_q[15]; // R1 R5
      pad_cfg_o <= pad_q;
    end
  end

  // input buffers: host fills, software drains
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_full_q <= 4'h0;
      input_overflow_q <= 1'b0;
      for (int i = 0; i < 4; i++)
        in_buf_q[i] <= 8'h00;
    end else begin
      if (rd_req && wb_adr_i >= OFF_IN0 && wb_adr_i < OFF_IN0 + 8'h10)
        in_full_q[wb_adr_i[3:2] - 2'b10] <= 1'b0; // R11
      if (wr_req && wb_adr_i == OFF_STAT && wb_sel_i[1] && !wdat[ST_INPUT_OVERFLOW])
        input_overflow_q <= 1'b0; // R10
      if (host_wr_ev) begin
        if (in_full_q[in_idx])
          input_overflow_q <= 1'b1; // R10 R19
        else begin
          in_buf_q[in_idx] <= sync2_q.data;
          in_full_q[in_idx] <= 1'b1; // R11
        end
      end
    end
  end

  // output buffers: software fills, host drains
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_empty_q <= 4'hF;
      output_underflow_q <= 1'b0;
      for (int i = 0; i < 4; i++)
        out_buf_q[i] <= 8'h00;
    end else begin
      if (host_rd_ev) begin
        if (out_empty_q[out_idx])
          output_underflow_q <= 1'b1; // R13
        else
          out_empty_q[out_idx] <= 1'b1; // R12
      end
      if (wr_req && wb_adr_i == OFF_STAT && wb_sel_i[0] && !wdat[ST_OUTPUT_UNDERFLOW] && !host_rd_ev)
        output_underflow_q <= 1'b0; // R13
      if (wr_req && wb_adr_i >= OFF_OUT0 && wb_adr_i < OFF_OUT0 + 8'h10 && wb_sel_i[0]) begin
        out_buf_q[wb_adr_i[3:2] - 2'b10] <= wdat[7:0];
        out_empty_q[wb_adr_i[3:2] - 2'b10] <= 1'b0; // R14
      end
      if (wr_req && wb_adr_i == OFF_ADDR && enh) begin
        if (wb_sel_i[0]) begin
          out_buf_q[2] <= wdat[7:0]; // R4
          out_empty_q[2] <= 1'b0; // R14
        end
        if (wb_sel_i[1]) begin
          out_buf_q[3] <= wdat[15:8]; // R4
          out_empty_q[3] <= 1'b0; // R14
        end
      end
    end
  end

  // host read data drive and interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_data_o <= 8'h00;
      host_data_oe_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      if (host_rd_ev)
        host_data_o <= out_buf_q[out_idx];
      host_data_oe_o <= sync2_q.cs & sync2_q.rd & (mode == MODE_LEGACY | enh);
      irq_o <= ((interrupt_mode_field == IRQ_BUF3) & (host_wr_ev & in_idx == 2'b11 | host_rd_ev & out_idx == 2'b11)) |
               ((interrupt_mode_field == IRQ_END) & (host_wr_ev | host_rd_ev | master_wr_o)); // R18
    end
  end

  // wishbone answer, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      rdat_q <= 32'h00000000;
      if (rd_req) begin
        if (wb_adr_i == OFF_CTRL)
          rdat_q[15:0] <= ctrl_q;
        else if (wb_adr_i == OFF_ADDR)
          rdat_q[15:0] <= enh ? {out_buf_q[3], out_buf_q[2]} : addr_q; // R4
        else if (wb_adr_i == OFF_AEN)
          rdat_q[15:0] <= aen_q;
        else if (wb_adr_i == OFF_STAT)
          rdat_q[15:0] <= status; // R15
        else if (wb_adr_i == OFF_PAD)
          rdat_q[15:0] <= pad_q;
        else if (wb_adr_i >= OFF_IN0 && wb_adr_i < OFF_IN0 + 8'h10)
          rdat_q[7:0] <= in_buf_q[wb_adr_i[3:2] - 2'b10];
        else if (wb_adr_i >= OFF_OUT0 && wb_adr_i < OFF_OUT0 + 8'h10)
          rdat_q[7:0] <= out_buf_q[wb_adr_i[3:2] - 2'b10];
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
endmodule : ppa_top

// ---- include/ppa_pkg.sv ----
// Purpose: shared constants and types for the parallel port address/status block
// Assumes: 32-bit classic wishbone, 16-bit registers in the low half of each word
// Notes: byte offsets are word aligned
package ppa_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_AEN = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_PAD = 8'h10;
  localparam logic [7:0] OFF_MDATA = 8'h14;
  localparam logic [7:0] OFF_IN0 = 8'h18;
  localparam logic [7:0] OFF_OUT0 = 8'h28;
  localparam logic [7:0] OFF_STEP = 8'h04;
  // control register fields
  localparam int CSF_LSB = 6;
  localparam int MODE_LSB = 8;
  localparam int STEP_LSB = 11;
  localparam int INTERRUPT_MODE_FIELD_LSB = 13;
  // status register fields
  localparam int ST_IBF = 15;
  localparam int ST_INPUT_OVERFLOW = 14;
  localparam int ST_OBE = 7;
  localparam int ST_OUTPUT_UNDERFLOW = 6;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] AEN_RST = 16'h0000;
  localparam logic [15:0] PAD_RST = 16'h0000;
  localparam logic [15:0] PAD_MASK = 16'h0003;
  localparam logic [1:0] CSF_BOTH = 2'b10;
  localparam logic [1:0] CSF_TWO = 2'b01;
  localparam logic [1:0] STEP_INC = 2'b01;
  localparam logic [1:0] STEP_DEC = 2'b10;
  localparam logic [1:0] STEP_BUF = 2'b11;
  localparam logic [1:0] IRQ_END = 2'b01;
  localparam logic [1:0] IRQ_BUF3 = 2'b11;
  localparam logic [1:0] MODE_LEGACY = 2'b00;
  localparam logic [1:0] MODE_ENH = 2'b01;
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [1:0] addr;
    logic [7:0] data;
  } ppa_host_t;
endpackage : ppa_pkg

// ---- sim/ppa_assertions.sv ----
// Purpose: port checks for ppa_top
// Assumes: one clock, synchronous reset
// Notes: bound to every ppa_top
`timescale 1ns/1ps
module ppa_assertions
  import ppa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [15:0] port_addr_o,
  input wire logic [15:0] port_pin_en_o,
  input wire logic chip_select_one_o,
  input wire logic chip_select_two_o,
  input wire logic master_wr_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_quiet2;
    !irq_o [*2];
  endsequence
  a_ack_follows_req: assert property (s_req |=> wb_ack_o) else $error("ack missing");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_read_top_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper read bits set");
  a_pins_gate_addr: assert property ((port_addr_o & ~port_pin_en_o) == 16'h0000)
    else $error("address on disabled pin");
  a_cs2_pin_owned: assert property (chip_select_two_o |-> port_pin_en_o[15] && !port_addr_o[15])
    else $error("second select misplaced");
  a_cs1_pin_owned: assert property (chip_select_one_o |-> port_pin_en_o[14] && port_addr_o[15:14] == 2'b00)
    else $error("first select misplaced");
  a_master_cause: assert property (master_wr_o |-> $past(wb_we_i) && $past(wb_adr_i) == OFF_MDATA)
    else $error("master write without data write");
  a_irq_pulse: assert property (irq_o |=> s_quiet2) else $error("irq too long");
endmodule : ppa_assertions

bind ppa_top ppa_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_addr_o(port_addr_o),
  .port_pin_en_o(port_pin_en_o), .chip_select_one_o(chip_select_one_o), .chip_select_two_o(chip_select_two_o),
  .master_wr_o(master_wr_o), .irq_o(irq_o));

// ---- sim/ppa_host_model.sv ----
// Purpose: external host on the slave side
// Assumes: strobes high and low five clocks each
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module ppa_host_model
  import ppa_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] host_data_i,
  input wire logic host_data_oe_i,
  output ppa_pkg::ppa_host_t host_o
);
  initial begin
    host_o = '0;
  end
  task automatic xfer(input logic wr, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
    host_o <= {1'b1, !wr, wr, a, d};
    repeat (5) @(posedge clk_i);
    q = host_data_oe_i ? host_data_i : 8'h00;
    host_o <= {3'b000, ~a, ~d};
    repeat (5) @(posedge clk_i);
  endtask : xfer
endmodule : ppa_host_model

// ---- sim/test_parallel_port_addr_and_slave_status.sv ----
// Purpose: self-checking bench for ppa_top
// Assumes: one-cycle wishbone answer
// Notes: register table first, then hand cases
`timescale 1ns/1ps
module test_parallel_port_addr_and_slave_status;
  import ppa_pkg::*;
  typedef struct packed {logic [7:0] adr; logic [15:0] wd; logic [15:0] exp;} ppa_row_t;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, master_wr_o, irq_o, cs1, cs2, oe;
  logic [7:0] wb_adr_i, host_data_o, master_data_o, q;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] port_addr_o, pin_en, pad, r;
  ppa_host_t host_i;
  int bad_count, comparisons, irqs, wrs;
  ppa_row_t rows [4] = '{'{OFF_ADDR, 16'hA5C3, 16'hA5C3}, '{OFF_AEN, 16'hFFFF, 16'hFFFF},
    '{OFF_PAD, 16'hFFFF, 16'h0003}, '{8'h3C, 16'hFFFF, 16'h0000}};
  logic [1:0] steps [4] = '{STEP_INC, STEP_DEC, STEP_DEC, 2'b00};
  logic [15:0] aexp [4] = '{16'h0001, 16'h0000, 16'hFFFF, 16'hFFFF};
  ppa_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .host_i(host_i), .host_data_o(host_data_o), .host_data_oe_o(oe), .port_addr_o(port_addr_o),
    .port_pin_en_o(pin_en), .chip_select_one_o(cs1), .chip_select_two_o(cs2), .master_data_o(master_data_o),
    .master_wr_o(master_wr_o), .pad_cfg_o(pad), .irq_o(irq_o));
  ppa_host_model host (.clk_i(clk_i), .host_data_i(host_data_o), .host_data_oe_i(oe), .host_o(host_i));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (irq_o === 1'b1) irqs++;
    if (master_wr_o === 1'b1) wrs++;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d, output logic [15:0] rd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    rst_i = 1'b1;
    wb_sel_i = 4'h3;
    {bad_count, comparisons, irqs, wrs} = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    foreach (rows[i]) begin
      wb(1'b1, rows[i].adr, rows[i].wd, r);
      wb(1'b0, rows[i].adr, 16'h0000, r);
      check(r, rows[i].exp);
    end
    check(pad, 16'h0003);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, OFF_ADDR, 16'h0000, r);
    check(r, 16'h0000);
    wb(1'b0, OFF_STAT, 16'h0000, r);
    check(r, 16'h008F);
    wb(1'b1, OFF_AEN, 16'hFFFF, r);
    check(pin_en, 16'hFFFF);
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, OFF_CTRL, 16'h0200 | 16'(c << 6), r);
      wb(1'b1, OFF_ADDR, 16'hC005, r);
      check({14'h0000, cs2, cs1}, {14'h0000, c == 1 || c == 2, c == 2});
      check(port_addr_o, {c == 0 || c == 3, c != 2, 14'h0005});
    end
    wb(1'b1, OFF_ADDR, 16'h0000, r);
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, OFF_CTRL, 16'h0200 | {3'b000, steps[s], 11'h000}, r);
      wb(1'b1, OFF_MDATA, {8'h00, 8'h50 + 8'(s)}, r);
      wb(1'b0, OFF_ADDR, 16'h0000, r);
      check(r, aexp[s]);
      check({8'h00, master_data_o}, {8'h00, 8'h50 + 8'(s)});
    end
    check(16'(wrs), 16'h0004);
    wb(1'b1, OFF_CTRL, 16'h6100, r);
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b1, 2'(i), 8'h10 + 8'(i), q);
      wb(1'b0, OFF_STAT, 16'h0000, r);
      check(r, {i == 3, 3'b000, 4'((2 << i) - 1), 8'h8F});
    end
    check(16'(irqs), 16'h0001);
    host.xfer(1'b1, 2'd1, 8'hEE, q);
    wb(1'b0, OFF_IN0 + OFF_STEP, 16'h0000, r);
    check(r, 16'h0011);
    wb(1'b0, OFF_STAT, 16'h0000, r);
    check(r, 16'h4D8F);
    wb(1'b1, OFF_STAT, 16'h0000, r);
    wb(1'b1, OFF_OUT0, 16'h0077, r);
    wb(1'b1, OFF_ADDR, 16'h3344, r);
    wb(1'b0, OFF_STAT, 16'h0000, r);
    check(r, 16'h0D02);
    host.xfer(1'b0, 2'd0, 8'h00, q);
    check({8'h00, q}, 16'h0077);
    host.xfer(1'b0, 2'd3, 8'h00, q);
    check({8'h00, q}, 16'h0033);
    host.xfer(1'b0, 2'd3, 8'h00, q);
    wb(1'b0, OFF_STAT, 16'h0000, r);
    check(r, 16'h0D4B);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b1, OFF_CTRL, 16'h3800, r);
    host.xfer(1'b1, 2'd3, 8'hA0, q);
    host.xfer(1'b1, 2'd3, 8'hA1, q);
    wb(1'b0, OFF_STAT, 16'h0000, r);
    check(r, 16'h038F);
    wb(1'b0, OFF_IN0 + OFF_STEP, 16'h0000, r);
    check(r, 16'h00A1);
    check(16'(irqs), 16'h0005);
    wb(1'b1, OFF_CTRL, 16'h2B00, r);
    wb(1'b1, OFF_MDATA, 16'h0066, r);
    wb(1'b0, OFF_ADDR, 16'h0000, r);
    check(r, 16'h0001);
    check(16'(wrs), 16'h0005);
    check(16'(irqs), 16'h0006);
    summarize();
  end
endmodule : test_parallel_port_addr_and_slave_status
